// File: verilog/arx_pkg.sv
package arx_pkg;
   // SPI op-codes.
   localparam logic [7:0] OP_WR_CTRL1 = 8'h10;
   localparam logic [7:0] OP_WR_CTRL2 = 8'h24;
   localparam logic [7:0] OP_WR_LBL2 = 8'h28;
   localparam logic [7:0] OP_WR_PL2 = 8'h2c;
   localparam logic [7:0] OP_WR_FLAG = 8'h34;
   localparam logic [7:0] OP_WR_DIV = 8'h38;
   localparam logic [7:0] OP_RD_CTRL1 = 8'h94;
   localparam logic [7:0] OP_RD_CTRL2 = 8'hb4;
   localparam logic [7:0] OP_RD_LBL2 = 8'hb8;
   localparam logic [7:0] OP_RD_PL2 = 8'hbc;
   localparam logic [7:0] OP_RD_FIFO2 = 8'hc0;
   localparam logic [7:0] OP_RD_MB1 = 8'hc4;
   localparam logic [7:0] OP_RD_MB2 = 8'hc8;
   localparam logic [7:0] OP_RD_MB3 = 8'hcc;
   localparam logic [7:0] OP_RD_FLAG = 8'hd0;
   localparam logic [7:0] OP_RD_DIV = 8'hd4;
   localparam logic [7:0] OP_NOP = 8'hff;
   // Receiver control field positions.
   localparam int CB_REVERSE = 7;
   localparam int CB_MATCH9 = 6;
   localparam int CB_MATCH10 = 5;
   localparam int CB_SD_EN = 4;
   localparam int CB_PARITY = 3;
   localparam int CB_FILTER = 2;
   localparam int CB_PRIO = 1;
   localparam int CB_RATE = 0;
   // Reset values.
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] FLAG_RESET = 8'h00;
   localparam logic [7:0] DIV_RESET = 8'h00;
   localparam logic [255:0] LBL_RESET = 256'h0;
   localparam logic [7:0] LABEL_RESET = 8'h00;
   // Word layout and transfer lengths.
   localparam int WORD_W = 32;
   localparam int LABEL_W = 8;
   localparam int NUM_LABELS = 256;
   localparam int LBL_TOP = NUM_LABELS - 1;
   localparam int MB_W = 24;
   localparam int W_BIT9 = 8;
   localparam int W_BIT10 = 9;
   localparam int NUM_MB = 3;
   localparam logic [5:0] LBL_BYTES = 6'h20;
   localparam logic [5:0] PL_BYTES = 6'h03;
   localparam logic [5:0] WORD_BYTES = 6'h04;
   localparam logic [5:0] MB_BYTES = 6'h03;
   localparam logic [5:0] BYTE_MAX = 6'h3f;
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam int FIFO_DEPTH_DEF = 8;
   // Frame phase, Gray coded.
   typedef enum logic [1:0] {
      FR_OPCODE = 2'b00,
      FR_DATA = 2'b01
   } arx_frame_t;
endpackage

// File: verilog/arx_rx_ctrl.sv
// Operation
// - Op-code 0xB4 returns receiver two control byte.
// - Op-code 0xB8 returns 32 bytes of receiver two label table.
// - Op-code 0xBC returns receiver two three priority labels.
// - Op-code 0xC0 returns one 32-bit word from receiver two FIFO.
// - Op-codes 0xC4, 0xC8, 0xCC return mailbox one, two, three bits 9-32.
// - Op-code 0xD0 returns the flag assignment byte.
// - Op-code 0xD4 returns the clock divisor byte.
// - Op-code 0xFF does nothing and changes no state.
// - Control written by 0x10 and 0x24, read by 0x94 and 0xB4.
// - Control bit 7 reverses the label bits of each received word.
// - With matching on, word bits 9 and 10 must equal bits 6 and 5.
// - Control bit 4 enables matching; clear means bits 9, 10 ignored.
// - Control bit 3 enables odd parity check; clear stores all bits.
// - Control bit 2 set stores only words whose label entry is one.
// - Control bit 1 set captures priority labels into mailboxes.
// - Control bit 0 selects high speed or one eighth low speed.
// - Label table moves from label 0xFF downward, one bit per label.
// - Priority label bytes go filter three, then two, then one.
`timescale 1ns/1ps
module arx_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 8
) (
   // Clock and reset.
   input wire logic i_clk,
   input wire logic i_arst_n,
   input wire logic i_ce,
   // Fill side.
   input wire logic i_in_valid,
   input wire logic [WIDTH-1:0] i_in_data,
   output logic o_in_ready,
   // Drain side.
   output logic o_out_valid,
   output logic [WIDTH-1:0] o_out_data,
   input wire logic i_out_ready
);
   localparam int PW = $clog2(DEPTH);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PW-1:0] wr;
      logic [PW-1:0] rd;
      logic [PW:0] cnt;
      logic full;
      logic empty;
   } arx_fifo_t;
   arx_fifo_t q;
   arx_fifo_t d;
   logic push;
   logic pop;

   generate
      if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
         $error("FIFO depth must be a power of two of at least two.");
      end
   endgenerate

   always_comb begin
      d = q;
      push = i_in_valid && !q.full;
      pop = i_out_ready && !q.empty;
      if (push) begin
         d.mem[q.wr] = i_in_data;
         d.wr = q.wr + 1'b1;
      end
      if (pop) begin
         d.rd = q.rd + 1'b1;
      end
      if (push && !pop) begin
         d.cnt = q.cnt + 1'b1;
      end else if (pop && !push) begin
         d.cnt = q.cnt - 1'b1;
      end
      d.full = (d.cnt == (PW+1)'(DEPTH));
      d.empty = (d.cnt == '0);
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         q <= '{mem: '0, wr: '0, rd: '0, cnt: '0, full: 1'b0, empty: 1'b1};
      end else if (i_ce) begin
         q <= d;
      end
   end

   assign o_in_ready = !q.full;
   assign o_out_valid = !q.empty;
   assign o_out_data = q.mem[q.rd];
endmodule // arx_fifo

module arx_rx_ctrl #(
   parameter int FIFO_DEPTH = arx_pkg::FIFO_DEPTH_DEF
) (
   // System clock, reset and enable.
   input wire logic i_clk,
   input wire logic i_arst_n,
   input wire logic i_ce,
   // SPI link.
   input wire logic i_spi_sck,
   input wire logic i_spi_cs_n,
   input wire logic i_spi_mosi,
   output logic o_spi_miso,
   output logic o_spi_miso_oe,
   // Decoded words from the second receiver.
   input wire logic i_rx2_valid,
   input wire logic [31:0] i_rx2_word,
   output logic o_rx2_ready,
   // Configuration to the surrounding logic.
   output logic o_rx1_low_speed,
   output logic o_rx2_low_speed,
   output logic [7:0] o_flag_assign,
   output logic [7:0] o_aclk_div
);
   typedef struct packed {
      logic [2:0] bit_cnt;
      logic [5:0] byte_cnt;
      arx_pkg::arx_frame_t phase;
      logic [7:0] op;
      logic [6:0] sh_in;
      logic [7:0] sh_out;
   } arx_spi_t;

   typedef struct packed {
      logic [7:0] ctrl1;
      logic [7:0] ctrl2;
      logic [7:0] flag;
      logic [7:0] div;
      logic [arx_pkg::LBL_TOP:0] lbl;
      logic [arx_pkg::NUM_MB-1:0][7:0] pl;
      logic pop_tog;
   } arx_cfg_t;

   typedef struct packed {
      logic [2:0] cs_s;
      logic frame;
      logic [2:0] pop_s;
      logic pop_seen;
      arx_cfg_t snap;
      logic [arx_pkg::NUM_MB-1:0][arx_pkg::MB_W-1:0] mb_pend;
      logic [arx_pkg::NUM_MB-1:0][arx_pkg::MB_W-1:0] mb;
      logic [31:0] head;
      logic head_valid;
   } arx_core_t;

   localparam arx_cfg_t CFG_RESET = '{ctrl1: arx_pkg::CTRL_RESET,
      ctrl2: arx_pkg::CTRL_RESET, flag: arx_pkg::FLAG_RESET,
      div: arx_pkg::DIV_RESET, lbl: arx_pkg::LBL_RESET,
      pl: '0, pop_tog: 1'b0};

   arx_spi_t spi_q;
   arx_spi_t spi_d;
   arx_cfg_t cfg_q;
   arx_cfg_t cfg_d;
   arx_core_t core_q;
   arx_core_t core_d;
   logic miso_q;
   logic miso_oe_q;
   logic [7:0] byte_v;
   logic [31:0] lw;
   logic [7:0] ctl;
   logic sd_ok;
   logic par_ok;
   logic lbl_ok;
   logic [arx_pkg::NUM_MB-1:0] hit;
   logic take;
   logic fifo_push;
   logic fifo_ready;
   logic fifo_out_valid;
   logic [31:0] fifo_out_data;
   logic fifo_out_ready;

   // Reverses the order of a label byte.
   function automatic logic [7:0] rev8(input logic [7:0] b);
      logic [7:0] r;
      r = '0;
      for (int i = 0; i < 8; i++) begin
         r[i] = b[7-i];
      end
      return r;
   endfunction

   // Byte presented to the host at position idx of a read.
   function automatic logic [7:0] rd_byte(input logic [7:0] op,
                                          input logic [5:0] idx);
      logic [7:0] r;
      int i;
      r = '0;
      i = int'(idx);
      case (op)
         arx_pkg::OP_RD_CTRL1: begin
            if (idx == '0) r = cfg_q.ctrl1;
         end
         arx_pkg::OP_RD_CTRL2: begin
            if (idx == '0) r = cfg_q.ctrl2;
         end
         arx_pkg::OP_RD_LBL2: begin
            if (idx < arx_pkg::LBL_BYTES) begin
               r = cfg_q.lbl[arx_pkg::LBL_TOP - 8*i -: 8];
            end
         end
         arx_pkg::OP_RD_PL2: begin
            if (idx < arx_pkg::PL_BYTES) begin
               r = cfg_q.pl[arx_pkg::NUM_MB - 1 - i];
            end
         end
         arx_pkg::OP_RD_FIFO2: begin
            if (core_q.head_valid && idx < arx_pkg::WORD_BYTES) begin
               r = core_q.head[31 - 8*i -: 8];
            end
         end
         arx_pkg::OP_RD_MB1: begin
            if (idx < arx_pkg::MB_BYTES) r = core_q.mb[0][23 - 8*i -: 8];
         end
         arx_pkg::OP_RD_MB2: begin
            if (idx < arx_pkg::MB_BYTES) r = core_q.mb[1][23 - 8*i -: 8];
         end
         arx_pkg::OP_RD_MB3: begin
            if (idx < arx_pkg::MB_BYTES) r = core_q.mb[2][23 - 8*i -: 8];
         end
         arx_pkg::OP_RD_FLAG: begin
            if (idx == '0) r = cfg_q.flag;
         end
         arx_pkg::OP_RD_DIV: begin
            if (idx == '0) r = cfg_q.div;
         end
         default: begin
            r = '0;
         end
      endcase
      return r;
   endfunction

   // Link side: op-code byte, then data bytes, MSB first.
   always_comb begin
      int lm;
      lm = 0;
      spi_d = spi_q;
      cfg_d = cfg_q;
      byte_v = {spi_q.sh_in, i_spi_mosi};
      spi_d.bit_cnt = spi_q.bit_cnt + 3'h1;
      spi_d.sh_in = byte_v[6:0];
      spi_d.sh_out = {spi_q.sh_out[6:0], 1'b0};
      if (spi_q.bit_cnt == arx_pkg::BIT_LAST) begin
         case (spi_q.phase)
            arx_pkg::FR_OPCODE: begin
               spi_d.op = byte_v;
               spi_d.phase = arx_pkg::FR_DATA;
               spi_d.byte_cnt = '0;
               spi_d.sh_out = rd_byte(byte_v, 6'h00);
               if (byte_v == arx_pkg::OP_RD_FIFO2 && core_q.head_valid) begin
                  cfg_d.pop_tog = ~cfg_q.pop_tog;
               end
            end
            arx_pkg::FR_DATA: begin
               lm = arx_pkg::LBL_TOP - 8*int'(spi_q.byte_cnt);
               case (spi_q.op)
                  arx_pkg::OP_WR_CTRL1: begin
                     if (spi_q.byte_cnt == '0) cfg_d.ctrl1 = byte_v;
                  end
                  arx_pkg::OP_WR_CTRL2: begin
                     if (spi_q.byte_cnt == '0) cfg_d.ctrl2 = byte_v;
                  end
                  arx_pkg::OP_WR_LBL2: begin
                     if (spi_q.byte_cnt < arx_pkg::LBL_BYTES) begin
                        cfg_d.lbl[lm -: 8] = byte_v;
                     end
                  end
                  arx_pkg::OP_WR_PL2: begin
                     if (spi_q.byte_cnt < arx_pkg::PL_BYTES) begin
                        cfg_d.pl[arx_pkg::NUM_MB - 1 - int'(spi_q.byte_cnt)] =
                           byte_v;
                     end
                  end
                  arx_pkg::OP_WR_FLAG: begin
                     if (spi_q.byte_cnt == '0) cfg_d.flag = byte_v;
                  end
                  arx_pkg::OP_WR_DIV: begin
                     if (spi_q.byte_cnt == '0) cfg_d.div = byte_v;
                  end
                  default: begin
                     cfg_d = cfg_q;
                  end
               endcase
               if (spi_q.byte_cnt != arx_pkg::BYTE_MAX) begin
                  spi_d.byte_cnt = spi_q.byte_cnt + 6'h01;
               end
               spi_d.sh_out = rd_byte(spi_q.op, spi_q.byte_cnt + 6'h01);
            end
            default: begin
               spi_d.phase = arx_pkg::FR_OPCODE;
            end
         endcase
      end
   end

   // Frame state restarts whenever chip select is high.
   always_ff @(posedge i_spi_sck or negedge i_arst_n or posedge i_spi_cs_n)
   begin
      if (!i_arst_n) begin
         spi_q <= '{bit_cnt: '0, byte_cnt: '0, phase: arx_pkg::FR_OPCODE,
                    op: '0, sh_in: '0, sh_out: '0};
      end else if (i_spi_cs_n) begin
         spi_q <= '{bit_cnt: '0, byte_cnt: '0, phase: arx_pkg::FR_OPCODE,
                    op: '0, sh_in: '0, sh_out: '0};
      end else begin
         spi_q <= spi_d;
      end
   end

   // Written settings persist across frames.
   always_ff @(posedge i_spi_sck or negedge i_arst_n) begin
      if (!i_arst_n) begin
         cfg_q <= CFG_RESET;
      end else begin
         cfg_q <= cfg_d;
      end
   end

   // Data leaves on the falling edge so the host samples on the rising one.
   always_ff @(negedge i_spi_sck or negedge i_arst_n or posedge i_spi_cs_n)
   begin
      if (!i_arst_n) begin
         miso_q <= 1'b0;
         miso_oe_q <= 1'b0;
      end else if (i_spi_cs_n) begin
         miso_q <= 1'b0;
         miso_oe_q <= 1'b0;
      end else begin
         miso_q <= spi_q.sh_out[7];
         miso_oe_q <= 1'b1;
      end
   end

   // Receive path on the system clock.
   always_comb begin
      ctl = core_q.snap.ctrl2;
      lw = i_rx2_word;
      if (ctl[arx_pkg::CB_REVERSE]) begin
         lw[7:0] = rev8(i_rx2_word[7:0]);
      end
      sd_ok = !ctl[arx_pkg::CB_SD_EN] ||
              (lw[arx_pkg::W_BIT9] == ctl[arx_pkg::CB_MATCH9] &&
               lw[arx_pkg::W_BIT10] == ctl[arx_pkg::CB_MATCH10]);
      par_ok = !ctl[arx_pkg::CB_PARITY] || (^lw);
      lbl_ok = !ctl[arx_pkg::CB_FILTER] ||
               core_q.snap.lbl[lw[7:0]];
      for (int k = 0; k < arx_pkg::NUM_MB; k++) begin
         hit[k] = ctl[arx_pkg::CB_PRIO] &&
                  lw[7:0] == core_q.snap.pl[k];
      end
      take = i_rx2_valid && fifo_ready;
      fifo_push = take && sd_ok && par_ok && lbl_ok && (hit == '0);
      fifo_out_ready = !core_q.frame && !core_q.head_valid;
   end

   always_comb begin
      core_d = core_q;
      core_d.cs_s = {core_q.cs_s[1:0], i_spi_cs_n};
      if (core_q.cs_s[1] == core_q.cs_s[2]) begin
         core_d.frame = ~core_q.cs_s[2];
      end
      core_d.pop_s = {core_q.pop_s[1:0], cfg_q.pop_tog};
      if (!core_q.frame && core_q.pop_s[1] == core_q.pop_s[2] &&
          core_q.pop_s[2] != core_q.pop_seen) begin
         core_d.pop_seen = core_q.pop_s[2];
         core_d.head_valid = 1'b0;
      end
      if (!core_q.frame) begin
         core_d.snap = cfg_q;
         core_d.mb = core_q.mb_pend;
      end
      if (take && sd_ok && par_ok) begin
         for (int k = 0; k < arx_pkg::NUM_MB; k++) begin
            if (hit[k]) begin
               core_d.mb_pend[k] = lw[31:8];
            end
         end
      end
      if (fifo_out_valid && fifo_out_ready) begin
         core_d.head = fifo_out_data;
         core_d.head_valid = 1'b1;
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         core_q <= '{cs_s: 3'h7, frame: 1'b0, pop_s: '0, pop_seen: 1'b0,
                     snap: CFG_RESET, mb_pend: '0, mb: '0, head: '0,
                     head_valid: 1'b0};
      end else if (i_ce) begin
         core_q <= core_d;
      end
   end

   arx_fifo #(
      .WIDTH(arx_pkg::WORD_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .i_clk(i_clk),
      .i_arst_n(i_arst_n),
      .i_ce(i_ce),
      .i_in_valid(fifo_push),
      .i_in_data(lw),
      .o_in_ready(fifo_ready),
      .o_out_valid(fifo_out_valid),
      .o_out_data(fifo_out_data),
      .i_out_ready(fifo_out_ready)
   );

   assign o_spi_miso = miso_q;
   assign o_spi_miso_oe = miso_oe_q;
   assign o_rx2_ready = fifo_ready;
   assign o_rx1_low_speed = core_q.snap.ctrl1[arx_pkg::CB_RATE];
   assign o_rx2_low_speed = core_q.snap.ctrl2[arx_pkg::CB_RATE];
   assign o_flag_assign = core_q.snap.flag;
   assign o_aclk_div = core_q.snap.div;
endmodule // arx_rx_ctrl

// File: verification/arx_rx_ctrl_monitor.sv
`timescale 1ns/1ps
module arx_rx_ctrl_monitor #(
   parameter int FIFO_DEPTH = 8
) (
   // Clock, reset and enable.
   input wire logic i_clk,
   input wire logic i_arst_n,
   input wire logic i_ce,
   // Link.
   input wire logic i_spi_sck,
   input wire logic i_spi_cs_n,
   input wire logic i_spi_mosi,
   input wire logic o_spi_miso,
   input wire logic o_spi_miso_oe,
   // Receive path and settings.
   input wire logic i_rx2_valid,
   input wire logic [31:0] i_rx2_word,
   input wire logic o_rx2_ready,
   input wire logic o_rx1_low_speed,
   input wire logic o_rx2_low_speed,
   input wire logic [7:0] o_flag_assign,
   input wire logic [7:0] o_aclk_div
);
   logic [5:0] rise_q;
   logic [7:0] op_q;
   // Counts link rises within a frame and keeps the op-code.
   always_ff @(posedge i_spi_sck or posedge i_spi_cs_n) begin
      if (i_spi_cs_n) begin
         rise_q <= 6'h00;
         op_q <= 8'h00;
      end else begin
         if (rise_q < 6'h08) begin
            op_q <= {op_q[6:0], i_spi_mosi};
         end
         if (rise_q != 6'h3f) begin
            rise_q <= rise_q + 6'h01;
         end
      end
   end
   sequence s_idle_two;
      i_spi_cs_n && $past(i_spi_cs_n);
   endsequence
   sequence s_taken;
      $past(i_rx2_valid) && $past(i_ce);
   endsequence
   property p_oe_idle;
      @(posedge i_clk) disable iff (!i_arst_n)
      i_spi_cs_n |-> !o_spi_miso_oe && !o_spi_miso;
   endproperty
   property p_oe_frame;
      @(posedge i_spi_sck) disable iff (i_spi_cs_n || !i_arst_n)
      rise_q != 6'h00 |-> o_spi_miso_oe;
   endproperty
   property p_nop_quiet;
      @(posedge i_spi_sck) disable iff (i_spi_cs_n || !i_arst_n)
      (rise_q >= 6'h08 && op_q == arx_pkg::OP_NOP) |-> !o_spi_miso;
   endproperty
   property p_rate2;
      @(posedge i_clk) disable iff (!i_arst_n)
      $changed(o_rx2_low_speed) |-> s_idle_two;
   endproperty
   property p_rate1;
      @(posedge i_clk) disable iff (!i_arst_n)
      $changed(o_rx1_low_speed) |-> s_idle_two;
   endproperty
   property p_settings;
      @(posedge i_clk) disable iff (!i_arst_n)
      !$stable({o_flag_assign, o_aclk_div}) |-> s_idle_two;
   endproperty
   property p_full_cause;
      @(posedge i_clk) disable iff (!i_arst_n)
      $fell(o_rx2_ready) |-> s_taken;
   endproperty
   property p_reset_vals;
      @(posedge i_clk) disable iff (!i_arst_n)
      $rose(i_arst_n) |-> o_rx2_ready && !o_rx1_low_speed &&
         !o_rx2_low_speed && o_flag_assign == 8'h00 && o_aclk_div == 8'h00;
   endproperty
   a_oe_idle: assert property (p_oe_idle)
      else $error("miso driven while deselected");
   a_oe_frame: assert property (p_oe_frame)
      else $error("miso not driven within frame");
   a_nop_quiet: assert property (p_nop_quiet)
      else $error("miso active after no-operation code");
   a_rate2: assert property (p_rate2)
      else $error("receiver two rate changed within frame");
   a_rate1: assert property (p_rate1)
      else $error("receiver one rate changed within frame");
   a_settings: assert property (p_settings)
      else $error("flag or divisor changed within frame");
   a_full_cause: assert property (p_full_cause)
      else $error("ready fell without an offered word");
   a_reset_vals: assert property (p_reset_vals)
      else $error("outputs wrong after reset");
endmodule // arx_rx_ctrl_monitor
bind arx_rx_ctrl arx_rx_ctrl_monitor #(.FIFO_DEPTH(FIFO_DEPTH)) u_mon (
   .i_clk(i_clk), .i_arst_n(i_arst_n), .i_ce(i_ce),
   .i_spi_sck(i_spi_sck), .i_spi_cs_n(i_spi_cs_n), .i_spi_mosi(i_spi_mosi),
   .o_spi_miso(o_spi_miso), .o_spi_miso_oe(o_spi_miso_oe),
   .i_rx2_valid(i_rx2_valid), .i_rx2_word(i_rx2_word),
   .o_rx2_ready(o_rx2_ready), .o_rx1_low_speed(o_rx1_low_speed),
   .o_rx2_low_speed(o_rx2_low_speed), .o_flag_assign(o_flag_assign),
   .o_aclk_div(o_aclk_div)
);

// File: verification/arx_spi_host.sv
`timescale 1ns/1ps
module arx_spi_host (
   // Link pins.
   output logic o_sck,
   output logic o_cs_n,
   output logic o_mosi,
   input wire logic i_miso
);
   initial begin
      o_sck = 1'b0;
      o_cs_n = 1'b1;
      o_mosi = 1'b0;
   end
   // Sends op-code then n bytes MSB first; the clock stands still outside.
   task automatic frame(input logic [7:0] op, input int n,
         input logic [255:0] wd, output logic [255:0] rd);
      rd = '0;
      #7;
      o_cs_n = 1'b0;
      #24;
      for (int i = 0; i < 8 * n + 8; i++) begin
         o_mosi = (i < 8) ? op[7-i] : wd[8*n-1-(i-8)];
         #24 o_sck = 1'b1;
         if (i >= 8) begin
            rd = {rd[254:0], i_miso};
         end
         #24 o_sck = 1'b0;
      end
      #24 o_cs_n = 1'b1;
      o_mosi = ~o_mosi;
      // Gap between frames lets settings and FIFO head cross over.
      #300;
   endtask
endmodule // arx_spi_host

// File: verification/tb_arx_rx_ctrl.sv
`timescale 1ns/1ps
module tb_arx_rx_ctrl;
   localparam logic [31:0] WR_OPS = {arx_pkg::OP_WR_CTRL1,
      arx_pkg::OP_WR_CTRL2, arx_pkg::OP_WR_FLAG, arx_pkg::OP_WR_DIV};
   localparam logic [31:0] RD_OPS = {arx_pkg::OP_RD_CTRL1,
      arx_pkg::OP_RD_CTRL2, arx_pkg::OP_RD_FLAG, arx_pkg::OP_RD_DIV};
   localparam logic [23:0] MB_OPS = {arx_pkg::OP_RD_MB1,
      arx_pkg::OP_RD_MB2, arx_pkg::OP_RD_MB3};
   localparam logic [7:0] RD_FIFO = arx_pkg::OP_RD_FIFO2;
   localparam logic [31:0] CTLS = 32'h80506cb4;
   logic clk, arst_n, ce, sck, cs_n, mosi, miso, miso_oe, miso_w;
   logic rx2_valid, rx2_ready, rx1_ls, rx2_ls;
   logic [31:0] rx2_word;
   logic [7:0] flag, div;
   logic [255:0] exp_q[$], seen_q[$], tbl, rd;
   string name_q[$];
   int failures, checks;
   int unsigned cyc;
   assign miso_w = miso_oe ? miso : 1'bz;
   arx_rx_ctrl #(.FIFO_DEPTH(8)) DUT (.i_clk(clk), .i_arst_n(arst_n),
      .i_ce(ce), .i_spi_sck(sck), .i_spi_cs_n(cs_n), .i_spi_mosi(mosi),
      .o_spi_miso(miso), .o_spi_miso_oe(miso_oe), .i_rx2_valid(rx2_valid),
      .i_rx2_word(rx2_word), .o_rx2_ready(rx2_ready),
      .o_rx1_low_speed(rx1_ls), .o_rx2_low_speed(rx2_ls),
      .o_flag_assign(flag), .o_aclk_div(div));
   arx_spi_host u_host (.o_sck(sck), .o_cs_n(cs_n), .o_mosi(mosi),
      .i_miso(miso_w));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic check(string nm, logic [255:0] seen, logic [255:0] e);
      checks++;
      if (seen !== e) begin
         failures++;
         $display("wrong value %s expected %0h seen %0h", nm, e, seen);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic post(string nm, logic [255:0] v);
      name_q.push_back(nm);
      seen_q.push_back(v);
   endtask
   task automatic rd_exp(logic [7:0] op, int n, logic [255:0] wd,
         logic [255:0] e);
      exp_q.push_back(e);
      u_host.frame(op, n, wd, rd);
      post("miso data", rd);
   endtask
   task automatic wr(logic [7:0] op, int n, logic [255:0] d);
      u_host.frame(op, n, d, rd);
   endtask
   task automatic send(logic [31:0] w);
      int k;
      @(posedge clk);
      rx2_valid <= 1'b1;
      rx2_word <= w;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (rx2_ready !== 1'b1 && k < 3000);
      rx2_valid <= 1'b0;
      if (k >= 3000) begin
         failures++;
      end
   endtask
   function automatic logic [31:0] rev(logic [31:0] w, logic [7:0] c);
      rev = w;
      for (int i = 0; i < 8; i++) begin
         rev[i] = c[7] ? w[7-i] : w[i];
      end
   endfunction
   function automatic bit keep(logic [31:0] w, logic [7:0] c);
      keep = !(c[4] && (w[8] != c[6] || w[9] != c[5]))
         && !(c[3] && !(^w))
         && !(c[2] && !tbl[w[7:0]]);
   endfunction
   // Watches results and compares each with the oldest note.
   always @(negedge clk) begin
      while (seen_q.size() > 0) begin
         check(name_q.pop_front(), seen_q.pop_front(), exp_q.pop_front());
      end
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 30000) begin
         failures++;
         give_verdict();
      end
   end
   initial begin
      logic [31:0] w, acc[$], mb[3];
      logic [7:0] c, cv[4], pl[3];
      int unsigned s;
      arst_n = 1'b0;
      ce = 1'b1;
      rx2_valid = 1'b0;
      rx2_word = 32'h0;
      s = $urandom(80);
      repeat (8) @(posedge clk);
      arst_n <= 1'b1;
      repeat (2) @(posedge clk);
      for (int k = 0; k < 4; k++) begin
         rd_exp(RD_OPS[31-8*k -: 8], 1, '0, '0);
      end
      $display("test reset done");
      for (int k = 0; k < 4; k++) begin
         cv[k] = $urandom;
         wr(WR_OPS[31-8*k -: 8], 1, cv[k]);
         rd_exp(RD_OPS[31-8*k -: 8], 1, '0, cv[k]);
      end
      exp_q.push_back({cv[0][0], cv[1][0], cv[2], cv[3]});
      post("settings", {rx1_ls, rx2_ls, flag, div});
      $display("test registers done");
      rd_exp(arx_pkg::OP_NOP, 2, 16'h24a5, '0);
      rd_exp(RD_OPS[23:16], 1, '0, cv[1]);
      $display("test nop done");
      for (int i = 0; i < 8; i++) begin
         tbl[32*i +: 32] = $urandom;
      end
      wr(arx_pkg::OP_WR_LBL2, 32, tbl);
      rd_exp(arx_pkg::OP_RD_LBL2, 32, '0, tbl);
      pl[0] = $urandom;
      pl[1] = pl[0] + 8'h01;
      pl[2] = pl[0] + 8'h02;
      wr(arx_pkg::OP_WR_PL2, 3, {pl[2], pl[1], pl[0]});
      rd_exp(arx_pkg::OP_RD_PL2, 3, '0, {pl[2], pl[1], pl[0]});
      $display("test tables done");
      for (int k = 0; k < 4; k++) begin
         c = CTLS[31-8*k -: 8];
         wr(WR_OPS[23:16], 1, c);
         for (int j = 0; j < 6; j++) begin
            w = $urandom;
            send(w);
            w = rev(w, c);
            if (keep(w, c)) begin
               acc.push_back(w);
            end
         end
         repeat (4) @(posedge clk);
         while (acc.size() > 0) begin
            rd_exp(RD_FIFO, 4, '0, acc.pop_front());
         end
         rd_exp(RD_FIFO, 4, '0, '0);
      end
      $display("test filter done");
      wr(WR_OPS[23:16], 1, 8'h00);
      for (int j = 0; j < 9; j++) begin
         w = $urandom;
         acc.push_back(w);
         send(w);
      end
      repeat (3) @(posedge clk);
      exp_q.push_back('0);
      post("rx2 ready", rx2_ready);
      w = $urandom;
      fork
         send(w);
      join_none
      for (int j = 0; j < 9; j++) begin
         rd_exp(RD_FIFO, 4, '0, acc.pop_front());
      end
      repeat (4) @(posedge clk);
      rd_exp(RD_FIFO, 4, '0, w);
      $display("test fifo done");
      wr(WR_OPS[23:16], 1, 8'h02);
      for (int j = 0; j < 3; j++) begin
         mb[j] = {$urandom, pl[j]};
         send(mb[j]);
      end
      repeat (4) @(posedge clk);
      for (int j = 0; j < 3; j++) begin
         rd_exp(MB_OPS[23-8*j -: 8], 3, '0, mb[j][31:8]);
      end
      rd_exp(RD_FIFO, 4, '0, '0);
      wr(WR_OPS[23:16], 1, 8'h00);
      w = {$urandom, pl[0]};
      send(w);
      repeat (4) @(posedge clk);
      rd_exp(RD_FIFO, 4, '0, w);
      rd_exp(MB_OPS[23:16], 3, '0, mb[0][31:8]);
      $display("test mailbox done");
      repeat (4) @(posedge clk);
      give_verdict();
   end
endmodule // tb_arx_rx_ctrl
